//--- inc/sdm_pkg.sv
// Constants and types shared by the section defect monitor
package sdm_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [15:0] SDM_ADDR_STATUS_HIGH = 16'h1106;
    localparam logic [15:0] SDM_ADDR_STATUS_LOW = 16'h1107;
    localparam logic [15:0] SDM_ADDR_CHANGE_FLAGS = 16'h1109;
    localparam logic [15:0] SDM_ADDR_CONTROL = 16'h1100;
    localparam logic [15:0] SDM_ADDR_INSYNC_THRESH = 16'h112B;
    localparam logic [15:0] SDM_ADDR_ZERO_RUN_HI = 16'h112E;
    localparam logic [15:0] SDM_ADDR_ZERO_RUN_LO = 16'h112F;
    localparam logic [15:0] SDM_ADDR_SF_THRESH = 16'h1130;
    localparam logic [15:0] SDM_ADDR_SD_THRESH = 16'h1131;
    localparam logic [15:0] SDM_ADDR_B2_INTERVAL = 16'h1132;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int SDM_BIT_SF_ENABLE = 6;
    localparam int SDM_BIT_SD_ENABLE = 5;
    localparam int SDM_BIT_AIS_CHANGE = 1;
    localparam int SDM_BIT_RDI_CHANGE = 0;
    // ----------------------------------------
    // Values after reset
    // ----------------------------------------
    localparam logic [7:0] SDM_RESET_BYTE = 8'h00;
    localparam logic [7:0] SDM_RESET_INTERVAL = 8'h08;
    // ----------------------------------------
    // K2 patterns and frame counts
    // ----------------------------------------
    localparam logic [2:0] SDM_K2_AIS = 3'h7;
    localparam logic [2:0] SDM_K2_RDI = 3'h6;
    localparam logic [2:0] SDM_PERSIST_FRAMES = 3'h5;
    localparam logic [5:0] SDM_S1_UNSTABLE_COUNT = 6'h20;
    localparam logic [3:0] SDM_S1_STABLE_FRAMES = 4'h8;
    localparam logic [3:0] SDM_K_UNSTABLE_FRAMES = 4'hC;
    localparam logic [3:0] SDM_K_STABLE_FRAMES = 4'h3;
    localparam logic [2:0] SDM_SEF_CLEAR_FRAMES = 3'h2;
    localparam int SDM_LOF_TIME_US = 3000;
    localparam int SDM_FRAME_PERIOD_US = 125;
    localparam logic [4:0] SDM_LOF_FRAMES = 5'(SDM_LOF_TIME_US / SDM_FRAME_PERIOD_US);
    // Errored framing patterns needed for SEF, per criteria select
    localparam logic [2:0] SDM_SEF_SET_0 = 3'h4;
    localparam logic [2:0] SDM_SEF_SET_1 = 3'h5;
    localparam logic [2:0] SDM_SEF_SET_2 = 3'h6;
    localparam logic [2:0] SDM_SEF_SET_3 = 3'h7;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic frame_strobe;
        logic framing_error;
        logic [7:0] k1;
        logic [7:0] k2;
        logic [7:0] s1;
        logic [7:0] b2_errors;
    } sdm_overhead_t;

    typedef enum logic [0:0] {
        SDM_SEF_CLEAR = 1'b0,
        SDM_SEF_DECLARED = 1'b1
    } sdm_sef_state_t;
endpackage : sdm_pkg

//--- core/sdm_persist.sv
// Five-frame persistence filter for one K2 pattern
`timescale 1ns/10ps
module sdm_persist
    import sdm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic frame_strobe,
    input wire logic match,
    output logic declared
);
    // ----------------------------------------
    // Count frames that disagree with the state
    // ----------------------------------------
    logic [2:0] run_reg;
    logic [2:0] run_next;
    logic declared_next;
    wire logic differs = match != declared;
    wire logic run_done = (run_reg + 3'h1) == SDM_PERSIST_FRAMES;

    assign run_next = !differs ? 3'h0 : run_done ? 3'h0 : run_reg + 3'h1;
    assign declared_next = (differs && run_done) ? match : declared;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_reg <= 3'h0;
            declared <= 1'b0;
        end else if (ce && frame_strobe) begin
            run_reg <= run_next;
            declared <= declared_next;
        end
    end
endmodule : sdm_persist

//--- core/sdm_monitor.sv
// Receive section overhead defect monitor with its status registers
// ----------------------------------------
// Notes on behaviour
// - MS-AIS declaration is a status bit, 1 while declared.
// - Declare MS-RDI after K2 bits 6-8 equal 110 for 5 frames.
// - S1 counter increments, up to 32, on each frame whose S1 differs from last.
// - S1 unstable declared when the S1 counter reaches 32.
// - S1 counter returns to zero after 8 frames of identical S1.
// - K1/K2 unstable declared after 12 frames without a repeated pair.
// - K1/K2 unstable cleared once a pair holds for three frames.
// - SF set when interval B2 errors exceed SF threshold, else cleared.
// - SD set when interval B2 errors exceed SD threshold, else cleared.
// - LOF declared after SEF has held for 24 frames, 3 ms.
// - SEF criteria chosen by a two-bit field at 0x112B.
// - LOS declared after a zero-byte run equal to the 16-bit limit.
// - Read-only status byte at 0x1107 holds eight defect bits.
// - Change flag byte at 0x1109, bit 1 MS-AIS, bit 0 MS-RDI.
// - MS-AIS change flag set on both declare and clear.
// - MS-RDI change flag set on both declare and clear.
// - Change flags read 1 after an event and clear on read.
// - MS-AIS declaration shown in bit 0 at 0x1106.
// - Declare MS-AIS after K2 bits 6-8 equal 111 for 5 frames.
// - SD neither declared nor cleared unless its enable is set.
// ----------------------------------------
`timescale 1ns/10ps
module sdm_monitor
    import sdm_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic [7:0] RX_BYTE,
    input wire logic RX_BYTE_VALID,
    input wire sdm_overhead_t OH_INFO,
    input wire logic [15:0] ADDR,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [7:0] WR_DATA,
    output logic [7:0] RD_DATA
);
    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_meta_reg;
    logic rst_n;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    wire logic frame = CE && OH_INFO.frame_strobe;
    wire logic wr_control = WR_EN && (ADDR == SDM_ADDR_CONTROL);
    wire logic wr_insync = WR_EN && (ADDR == SDM_ADDR_INSYNC_THRESH);
    wire logic wr_zero_hi = WR_EN && (ADDR == SDM_ADDR_ZERO_RUN_HI);
    wire logic wr_zero_lo = WR_EN && (ADDR == SDM_ADDR_ZERO_RUN_LO);
    wire logic wr_sf_thr = WR_EN && (ADDR == SDM_ADDR_SF_THRESH);
    wire logic wr_sd_thr = WR_EN && (ADDR == SDM_ADDR_SD_THRESH);
    wire logic wr_interval = WR_EN && (ADDR == SDM_ADDR_B2_INTERVAL);
    wire logic rd_flags = RD_EN && (ADDR == SDM_ADDR_CHANGE_FLAGS);

    logic [7:0] control_reg;
    logic [7:0] insync_reg;
    logic [15:0] zero_run_limit;
    logic [7:0] sf_thresh_reg;
    logic [7:0] sd_thresh_reg;
    logic [7:0] interval_reg;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            control_reg <= SDM_RESET_BYTE;
            insync_reg <= SDM_RESET_BYTE;
            zero_run_limit <= 16'h0000;
            sf_thresh_reg <= SDM_RESET_BYTE;
            sd_thresh_reg <= SDM_RESET_BYTE;
            interval_reg <= SDM_RESET_INTERVAL;
        end else if (CE) begin
            if (wr_control) control_reg <= WR_DATA;
            if (wr_insync) insync_reg <= WR_DATA;
            if (wr_zero_hi) zero_run_limit[15:8] <= WR_DATA;
            if (wr_zero_lo) zero_run_limit[7:0] <= WR_DATA;
            if (wr_sf_thr) sf_thresh_reg <= WR_DATA;
            if (wr_sd_thr) sd_thresh_reg <= WR_DATA;
            if (wr_interval) interval_reg <= WR_DATA;
        end
    end

    // ----------------------------------------
    // MS-AIS and MS-RDI persistence
    // ----------------------------------------
    logic [1:0] k2_declared;
    wire logic [2:0] k2_low = OH_INFO.k2[2:0];
    wire logic [1:0] k2_match = {k2_low == SDM_K2_AIS, k2_low == SDM_K2_RDI};
    wire logic ms_ais = k2_declared[1];
    wire logic ms_rdi = k2_declared[0];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_k2
            sdm_persist u_persist (
                .clk(CLK),
                .rst_n(rst_n),
                .ce(CE),
                .frame_strobe(OH_INFO.frame_strobe),
                .match(k2_match[g]),
                .declared(k2_declared[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // S1 instability
    // ----------------------------------------
    logic [7:0] s1_prev_reg;
    logic [5:0] s1_count_reg;
    logic [3:0] s1_same_reg;
    logic s1_unstable_reg;
    wire logic s1_differs = OH_INFO.s1 != s1_prev_reg;
    wire logic s1_settled = !s1_differs && (s1_same_reg + 4'h1 == SDM_S1_STABLE_FRAMES);
    wire logic s1_at_top = s1_count_reg == SDM_S1_UNSTABLE_COUNT;
    wire logic [5:0] s1_count_next = s1_settled ? 6'h00 :
        (s1_differs && !s1_at_top) ? s1_count_reg + 6'h01 : s1_count_reg;
    wire logic [3:0] s1_same_next = s1_differs ? 4'h1 :
        s1_settled ? 4'h0 : s1_same_reg + 4'h1;
    wire logic s1_unstable_next = (s1_count_next == SDM_S1_UNSTABLE_COUNT) ? 1'b1 :
        s1_settled ? 1'b0 : s1_unstable_reg;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            s1_prev_reg <= 8'h00;
            s1_count_reg <= 6'h00;
            s1_same_reg <= 4'h0;
            s1_unstable_reg <= 1'b0;
        end else if (frame) begin
            s1_prev_reg <= OH_INFO.s1;
            s1_count_reg <= s1_count_next;
            s1_same_reg <= s1_same_next;
            s1_unstable_reg <= s1_unstable_next;
        end
    end

    // ----------------------------------------
    // K1/K2 instability
    // ----------------------------------------
    logic [15:0] kpair_prev_reg;
    logic [3:0] k_change_reg;
    logic [3:0] k_hold_reg;
    logic k_unstable_reg;
    wire logic [15:0] kpair = {OH_INFO.k1, OH_INFO.k2};
    wire logic k_same = kpair == kpair_prev_reg;
    wire logic [3:0] k_change_next = k_same ? 4'h0 :
        (k_change_reg == SDM_K_UNSTABLE_FRAMES) ? k_change_reg : k_change_reg + 4'h1;
    wire logic [3:0] k_hold_next = !k_same ? 4'h1 :
        (k_hold_reg == SDM_K_STABLE_FRAMES) ? k_hold_reg : k_hold_reg + 4'h1;
    wire logic k_unstable_next = (k_change_next == SDM_K_UNSTABLE_FRAMES) ? 1'b1 :
        (k_hold_next == SDM_K_STABLE_FRAMES) ? 1'b0 : k_unstable_reg;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            kpair_prev_reg <= 16'h0000;
            k_change_reg <= 4'h0;
            k_hold_reg <= 4'h0;
            k_unstable_reg <= 1'b0;
        end else if (frame) begin
            kpair_prev_reg <= kpair;
            k_change_reg <= k_change_next;
            k_hold_reg <= k_hold_next;
            k_unstable_reg <= k_unstable_next;
        end
    end

    // ----------------------------------------
    // B2 interval accumulation, SF and SD
    // ----------------------------------------
    logic [15:0] b2_acc_reg;
    logic [7:0] b2_frames_reg;
    logic sf_reg;
    logic sd_reg;
    wire logic [15:0] b2_sum = b2_acc_reg + {8'h00, OH_INFO.b2_errors};
    wire logic interval_end = (b2_frames_reg + 8'h01) >= interval_reg;
    wire logic sf_enable = control_reg[SDM_BIT_SF_ENABLE];
    wire logic sd_enable = control_reg[SDM_BIT_SD_ENABLE];
    wire logic sf_over = b2_sum > {8'h00, sf_thresh_reg};
    wire logic sd_over = b2_sum > {8'h00, sd_thresh_reg};

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            b2_acc_reg <= 16'h0000;
            b2_frames_reg <= 8'h00;
            sf_reg <= 1'b0;
            sd_reg <= 1'b0;
        end else if (frame) begin
            b2_acc_reg <= interval_end ? 16'h0000 : b2_sum;
            b2_frames_reg <= interval_end ? 8'h00 : b2_frames_reg + 8'h01;
            if (interval_end && sf_enable) sf_reg <= sf_over;
            if (interval_end && sd_enable) sd_reg <= sd_over;
        end
    end

    // ----------------------------------------
    // SEF and LOF
    // ----------------------------------------
    sdm_sef_state_t sef_state;
    sdm_sef_state_t sef_state_next;
    logic [2:0] sef_run_reg;
    logic [4:0] lof_count_reg;
    logic lof_reg;
    logic [2:0] sef_set_frames;

    assign sef_set_frames = (insync_reg[1:0] == 2'h0) ? SDM_SEF_SET_0 :
        (insync_reg[1:0] == 2'h1) ? SDM_SEF_SET_1 :
        (insync_reg[1:0] == 2'h2) ? SDM_SEF_SET_2 : SDM_SEF_SET_3;

    wire logic sef_counting = (sef_state == SDM_SEF_CLEAR) ? OH_INFO.framing_error
        : !OH_INFO.framing_error;
    wire logic [2:0] sef_run_next = sef_counting ? sef_run_reg + 3'h1 : 3'h0;
    wire logic sef_set_hit = sef_run_next == sef_set_frames;
    wire logic sef_clear_hit = sef_run_next == SDM_SEF_CLEAR_FRAMES;
    wire logic sef = sef_state == SDM_SEF_DECLARED;

    always_comb begin
        sef_state_next = sef_state;
        unique case (sef_state)
            SDM_SEF_CLEAR: begin
                if (sef_set_hit) sef_state_next = SDM_SEF_DECLARED;
            end
            SDM_SEF_DECLARED: begin
                if (sef_clear_hit) sef_state_next = SDM_SEF_CLEAR;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            sef_state <= SDM_SEF_CLEAR;
            sef_run_reg <= 3'h0;
            lof_count_reg <= 5'h00;
            lof_reg <= 1'b0;
        end else if (frame) begin
            sef_state <= sef_state_next;
            sef_run_reg <= (sef_state_next != sef_state) ? 3'h0 : sef_run_next;
            lof_count_reg <= !sef ? 5'h00 :
                (lof_count_reg == SDM_LOF_FRAMES) ? lof_count_reg : lof_count_reg + 5'h01;
            lof_reg <= sef && (lof_count_reg + 5'h01 >= SDM_LOF_FRAMES);
        end
    end

    // ----------------------------------------
    // LOS zero-run detection
    // ----------------------------------------
    logic [15:0] zero_run_reg;
    logic los_reg;
    wire logic byte_in = CE && RX_BYTE_VALID;
    wire logic byte_zero = RX_BYTE == 8'h00;
    wire logic [15:0] zero_run_next = !byte_zero ? 16'h0000 :
        (zero_run_reg == 16'hFFFF) ? zero_run_reg : zero_run_reg + 16'h0001;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            zero_run_reg <= 16'h0000;
            los_reg <= 1'b0;
        end else if (byte_in) begin
            zero_run_reg <= zero_run_next;
            if (!byte_zero) los_reg <= 1'b0;
            else if (zero_run_next == zero_run_limit) los_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // Change flags, reset upon read
    // ----------------------------------------
    logic ais_prev_reg;
    logic rdi_prev_reg;
    logic ais_flag_reg;
    logic rdi_flag_reg;
    wire logic ais_change = ms_ais != ais_prev_reg;
    wire logic rdi_change = ms_rdi != rdi_prev_reg;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ais_prev_reg <= 1'b0;
            rdi_prev_reg <= 1'b0;
            ais_flag_reg <= 1'b0;
            rdi_flag_reg <= 1'b0;
        end else if (CE) begin
            ais_prev_reg <= ms_ais;
            rdi_prev_reg <= ms_rdi;
            ais_flag_reg <= ais_change || (ais_flag_reg && !rd_flags);
            rdi_flag_reg <= rdi_change || (rdi_flag_reg && !rd_flags);
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    wire logic [7:0] status_low = {ms_rdi, s1_unstable_reg, k_unstable_reg, sf_reg,
        sd_reg, lof_reg, sef, los_reg};
    wire logic [7:0] status_high = {7'h00, ms_ais};
    wire logic [7:0] change_flags = {6'h00, ais_flag_reg, rdi_flag_reg};
    logic [7:0] rd_mux;

    always_comb begin
        unique case (ADDR)
            SDM_ADDR_STATUS_HIGH: rd_mux = status_high;
            SDM_ADDR_STATUS_LOW: rd_mux = status_low;
            SDM_ADDR_CHANGE_FLAGS: rd_mux = change_flags;
            SDM_ADDR_CONTROL: rd_mux = control_reg;
            SDM_ADDR_INSYNC_THRESH: rd_mux = insync_reg;
            SDM_ADDR_ZERO_RUN_HI: rd_mux = zero_run_limit[15:8];
            SDM_ADDR_ZERO_RUN_LO: rd_mux = zero_run_limit[7:0];
            SDM_ADDR_SF_THRESH: rd_mux = sf_thresh_reg;
            SDM_ADDR_SD_THRESH: rd_mux = sd_thresh_reg;
            SDM_ADDR_B2_INTERVAL: rd_mux = interval_reg;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            RD_DATA <= 8'h00;
        end else if (CE && RD_EN) begin
            RD_DATA <= rd_mux;
        end
    end
endmodule : sdm_monitor

//--- tb/sdm_line_model.sv
// Receive line stream model: overhead frames and line bytes
`timescale 1ns/10ps
module sdm_line_model
    import sdm_pkg::*;
(
    input wire logic clk,
    output sdm_overhead_t oh,
    output logic [7:0] rx_byte,
    output logic rx_valid
);
    // ----------------------------------------
    // Stream drivers
    // ----------------------------------------
    int gap = 2;

    initial begin
        oh = '0;
        rx_byte = 8'hA5;
        rx_valid = 1'b0;
    end

    // Overhead fields valid only with the strobe
    task automatic send_frame(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] s1,
                              input logic [7:0] b2, input logic ferr);
        @(negedge clk);
        oh <= sdm_overhead_t'({1'b1, ferr, k1, k2, s1, b2});
        @(negedge clk);
        oh <= sdm_overhead_t'({1'b0, ~ferr, ~k1, ~k2, ~s1, ~b2});
        repeat (gap) @(negedge clk);
    endtask : send_frame

    // Each strobed byte, then the data lines invert
    task automatic send_bytes(input logic [7:0] val, input int n);
        repeat (n) begin
            @(negedge clk);
            rx_byte <= val;
            rx_valid <= 1'b1;
            @(negedge clk);
            rx_byte <= ~val;
            rx_valid <= 1'b0;
        end
    endtask : send_bytes
endmodule : sdm_line_model

//--- tb/sdm_chk_monitor.sv
// Port checker for the section defect monitor
`timescale 1ns/10ps
module sdm_chk
    import sdm_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic [7:0] RX_BYTE,
    input wire logic RX_BYTE_VALID,
    input wire sdm_overhead_t OH_INFO,
    input wire logic [15:0] ADDR,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [7:0] WR_DATA,
    input wire logic [7:0] RD_DATA
);
    // ----------------------------------------
    // Frame run counters
    // ----------------------------------------
    logic [2:0] ais_reg;
    logic [2:0] nais_reg;
    logic [2:0] rdi_reg;
    logic [2:0] nrdi_reg;
    wire take = CE && OH_INFO.frame_strobe;
    wire rd_on = CE && RD_EN;
    wire rd_flags = rd_on && (ADDR == SDM_ADDR_CHANGE_FLAGS);
    wire rd_high = rd_on && (ADDR == SDM_ADDR_STATUS_HIGH) && !take;
    wire rd_low = rd_on && (ADDR == SDM_ADDR_STATUS_LOW) && !take;
    wire is_ais = OH_INFO.k2[2:0] == 3'h7;
    wire is_rdi = OH_INFO.k2[2:0] == 3'h6;

    function automatic logic [2:0] step(input logic [2:0] v, input logic hit);
        return hit ? ((v == 3'h5) ? v : v + 3'h1) : 3'h0;
    endfunction : step

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ais_reg <= 3'h0;
            nais_reg <= 3'h0;
            rdi_reg <= 3'h0;
            nrdi_reg <= 3'h0;
        end else if (take) begin
            ais_reg <= step(ais_reg, is_ais);
            nais_reg <= step(nais_reg, !is_ais);
            rdi_reg <= step(rdi_reg, is_rdi);
            nrdi_reg <= step(nrdi_reg, !is_rdi);
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);

    sequence sq_flag_read;
        rd_flags && !take;
    endsequence

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_RD_HOLD: assert property (!rd_on |=> $stable(RD_DATA))
        else $error("read data moved without a read");
    AST_RST_ZERO: assert property ($rose(RESETN) |-> (RD_DATA == 8'h00) [*2])
        else $error("read data not zero after reset");
    AST_FLAG_UNUSED: assert property (rd_flags |=> RD_DATA[7:2] == 6'h00)
        else $error("unused flag bits read nonzero");
    AST_FLAG_CLEAR: assert property (!$past(take) ##0 sq_flag_read ##1 sq_flag_read |=> RD_DATA[1:0] == 2'h0)
        else $error("change flags not cleared by read");
    AST_AIS_SET: assert property (rd_high && ais_reg == 3'h5 |=> RD_DATA[0])
        else $error("line alarm not declared");
    AST_AIS_CLEAR: assert property (rd_high && nais_reg == 3'h5 |=> !RD_DATA[0])
        else $error("line alarm not cleared");
    AST_RDI_SET: assert property (rd_low && rdi_reg == 3'h5 |=> RD_DATA[7])
        else $error("remote defect not declared");
    AST_RDI_CLEAR: assert property (rd_low && nrdi_reg == 3'h5 |=> !RD_DATA[7])
        else $error("remote defect not cleared");
endmodule : sdm_chk

bind sdm_monitor sdm_chk i_chk (
    .CLK(CLK), .RESETN(RESETN), .CE(CE), .RX_BYTE(RX_BYTE), .RX_BYTE_VALID(RX_BYTE_VALID),
    .OH_INFO(OH_INFO), .ADDR(ADDR), .WR_EN(WR_EN), .RD_EN(RD_EN), .WR_DATA(WR_DATA),
    .RD_DATA(RD_DATA)
);

//--- tb/sdm_monitor_tb_top.sv
// Self-checking bench for the section defect monitor
`timescale 1ns/10ps
module sdm_monitor_tb_top
    import sdm_pkg::*;
;
    // ----------------------------------------
    // Harness
    // ----------------------------------------
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] rd_data;
    sdm_overhead_t oh_info;
    logic [7:0] rx_byte;
    logic rx_valid;
    int errors = 0;
    int checks = 0;
    int cyc = 0;

    sdm_monitor i_dut (
        .CLK(clk), .RESETN(resetn), .CE(ce), .RX_BYTE(rx_byte), .RX_BYTE_VALID(rx_valid),
        .OH_INFO(oh_info), .ADDR(addr), .WR_EN(wr_en), .RD_EN(rd_en), .WR_DATA(wr_data),
        .RD_DATA(rd_data)
    );
    sdm_line_model i_line (.clk(clk), .oh(oh_info), .rx_byte(rx_byte), .rx_valid(rx_valid));

    initial begin
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            errors++;
            final_report();
        end
    end

    task automatic final_report;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic rd(input logic [15:0] a, input logic [7:0] mask, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        @(negedge clk);
        check(rd_data & mask, exp);
    endtask : rd

    // Two back-to-back flag reads
    task automatic rd2(input logic [7:0] exp);
        @(negedge clk);
        addr = SDM_ADDR_CHANGE_FLAGS;
        rd_en = 1'b1;
        @(negedge clk);
        check(rd_data, exp);
        @(negedge clk);
        rd_en = 1'b0;
        check(rd_data, 8'h00);
    endtask : rd2

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wr_data = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask : wr

    task automatic fr(input int n, input logic [7:0] k1, input logic [7:0] k2,
                      input logic [7:0] s1, input logic [7:0] b2, input logic ferr);
        repeat (n) i_line.send_frame(k1, k2, s1, b2, ferr);
    endtask : fr

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd(SDM_ADDR_STATUS_LOW, 8'hFF, 8'h00);
        rd(SDM_ADDR_STATUS_HIGH, 8'h01, 8'h00);
        rd2(8'h00);
        wr(SDM_ADDR_STATUS_LOW, 8'hFF);
        wr(SDM_ADDR_CHANGE_FLAGS, 8'hFF);
        rd(SDM_ADDR_STATUS_LOW, 8'hFF, 8'h00);
        rd(16'h1108, 8'hFF, 8'h00);
        ce = 1'b0;
        fr(5, 8'h11, 8'h07, 8'h00, 8'h00, 1'b0);
        ce = 1'b1;
        rd(SDM_ADDR_STATUS_HIGH, 8'h01, 8'h00);
    endtask : t_reset

    task automatic t_k2;
        logic [7:0] pat [2] = '{8'h07, 8'h06};
        logic [15:0] adr [2] = '{SDM_ADDR_STATUS_HIGH, SDM_ADDR_STATUS_LOW};
        logic [7:0] msk [2] = '{8'h01, 8'h80};
        logic [7:0] flg [2] = '{8'h02, 8'h01};
        for (int j = 0; j < 2; j++) begin
            fr(4, 8'h11, pat[j], 8'h00, 8'h00, 1'b0);
            rd(adr[j], msk[j], 8'h00);
            fr(1, 8'h11, pat[j], 8'h00, 8'h00, 1'b0);
            rd(adr[j], msk[j], msk[j]);
            rd2(flg[j]);
            fr(4, 8'h11, 8'h00, 8'h00, 8'h00, 1'b0);
            rd(adr[j], msk[j], msk[j]);
            fr(1, 8'h11, 8'h00, 8'h00, 8'h00, 1'b0);
            rd(adr[j], msk[j], 8'h00);
            rd2(flg[j]);
        end
    endtask : t_k2

    task automatic t_kpair;
        for (int i = 0; i < 12; i++) begin
            if (i == 11) begin
                rd(SDM_ADDR_STATUS_LOW, 8'h20, 8'h00);
            end
            fr(1, 8'h20 + 8'(i), 8'h00, 8'h00, 8'h00, 1'b0);
        end
        rd(SDM_ADDR_STATUS_LOW, 8'h20, 8'h20);
        fr(2, 8'h55, 8'h00, 8'h00, 8'h00, 1'b0);
        rd(SDM_ADDR_STATUS_LOW, 8'h20, 8'h20);
        fr(1, 8'h55, 8'h00, 8'h00, 8'h00, 1'b0);
        rd(SDM_ADDR_STATUS_LOW, 8'h20, 8'h00);
    endtask : t_kpair

    task automatic t_sfsd;
        logic [7:0] b2 [3] = '{8'h03, 8'h05, 8'h06};
        logic [7:0] exp [3] = '{8'h08, 8'h08, 8'h18};
        wr(SDM_ADDR_SD_THRESH, 8'h10);
        wr(SDM_ADDR_SF_THRESH, 8'h28);
        wr(SDM_ADDR_CONTROL, 8'h60);
        for (int j = 0; j < 3; j++) begin
            fr(16, 8'h11, 8'h00, 8'h00, b2[j], 1'b0);
            rd(SDM_ADDR_STATUS_LOW, 8'h18, exp[j]);
        end
        wr(SDM_ADDR_CONTROL, 8'h40);
        fr(16, 8'h11, 8'h00, 8'h00, 8'h00, 1'b0);
        rd(SDM_ADDR_STATUS_LOW, 8'h18, 8'h08);
        wr(SDM_ADDR_CONTROL, 8'h60);
        fr(16, 8'h11, 8'h00, 8'h00, 8'h00, 1'b0);
        rd(SDM_ADDR_STATUS_LOW, 8'h18, 8'h00);
    endtask : t_sfsd

    task automatic t_sef;
        for (int j = 0; j < 4; j++) begin
            wr(SDM_ADDR_INSYNC_THRESH, 8'(j));
            fr(3 + j, 8'h11, 8'h00, 8'h00, 8'h00, 1'b1);
            rd(SDM_ADDR_STATUS_LOW, 8'h02, 8'h00);
            fr(1, 8'h11, 8'h00, 8'h00, 8'h00, 1'b1);
            rd(SDM_ADDR_STATUS_LOW, 8'h02, 8'h02);
            fr(2, 8'h11, 8'h00, 8'h00, 8'h00, 1'b0);
        end
        wr(SDM_ADDR_INSYNC_THRESH, 8'h00);
        fr(26, 8'h11, 8'h00, 8'h00, 8'h00, 1'b1);
        rd(SDM_ADDR_STATUS_LOW, 8'h06, 8'h02);
        fr(3, 8'h11, 8'h00, 8'h00, 8'h00, 1'b1);
        rd(SDM_ADDR_STATUS_LOW, 8'h06, 8'h06);
        fr(3, 8'h11, 8'h00, 8'h00, 8'h00, 1'b0);
        rd(SDM_ADDR_STATUS_LOW, 8'h06, 8'h00);
    endtask : t_sef

    task automatic t_los;
        wr(SDM_ADDR_ZERO_RUN_HI, 8'h01);
        wr(SDM_ADDR_ZERO_RUN_LO, 8'h02);
        i_line.send_bytes(8'h3C, 1);
        i_line.send_bytes(8'h00, 257);
        rd(SDM_ADDR_STATUS_LOW, 8'h01, 8'h00);
        i_line.send_bytes(8'h00, 1);
        rd(SDM_ADDR_STATUS_LOW, 8'h01, 8'h01);
        i_line.send_bytes(8'h80, 1);
        rd(SDM_ADDR_STATUS_LOW, 8'h01, 8'h00);
    endtask : t_los

    task automatic t_s1;
        i_line.gap = 0;
        for (int i = 0; i < 32; i++) begin
            if (i == 31) begin
                rd(SDM_ADDR_STATUS_LOW, 8'h40, 8'h00);
            end
            fr(1, 8'h11, 8'h00, i[0] ? 8'h00 : 8'h0F, 8'h00, 1'b0);
        end
        rd(SDM_ADDR_STATUS_LOW, 8'h40, 8'h40);
        fr(7, 8'h11, 8'h00, 8'h00, 8'h00, 1'b0);
        rd(SDM_ADDR_STATUS_LOW, 8'h40, 8'h00);
        for (int i = 0; i < 31; i++) begin
            fr(1, 8'h11, 8'h00, i[0] ? 8'h00 : 8'h0F, 8'h00, 1'b0);
        end
        rd(SDM_ADDR_STATUS_LOW, 8'h40, 8'h00);
    endtask : t_s1

    initial begin
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_k2();
        t_kpair();
        t_sfsd();
        t_sef();
        t_los();
        t_s1();
        final_report();
    end
endmodule : sdm_monitor_tb_top
